/* File: rtcd_pkg.sv */
// rtcd_pkg: constants, field layouts and carriers for the calendar time registers
// assumes: shared by the register block, its read holding register, the host model and the bench
package rtcd_pkg;

	// register indices on the three-bit register address
	localparam logic [2:0] ADDR_HUND = 3'h0;
	localparam logic [2:0] ADDR_SEC = 3'h1;
	localparam logic [2:0] ADDR_MIN = 3'h2;
	localparam logic [2:0] ADDR_HOUR = 3'h3;
	localparam logic [2:0] ADDR_DAY = 3'h4;
	localparam logic [2:0] ADDR_WDAY = 3'h5;
	localparam logic [2:0] ADDR_MON = 3'h6;
	localparam logic [2:0] ADDR_YEAR = 3'h7;
	localparam int NUM_REGS = 8;

	// bit positions of the status bits
	localparam int OSC_BIT = 7;
	localparam int SUMMARY_BIT = 7;
	localparam int PM_BIT = 5;

	// implemented-bit masks, unimplemented bits read as zero
	localparam logic [7:0] MASK_SEC = 8'h7F;
	localparam logic [7:0] MASK_MIN = 8'h7F;
	localparam logic [7:0] MASK_HOUR = 8'h3F;
	localparam logic [7:0] MASK_DAY = 8'h3F;
	localparam logic [7:0] MASK_WDAY = 8'h07;
	localparam logic [7:0] MASK_MON = 8'h1F;

	// reset values: 00:00:00.00, 2000-01-01, saturday
	localparam logic [7:0] RST_HUND = 8'h00;
	localparam logic [7:0] RST_SEC = 8'h00;
	localparam logic [7:0] RST_MIN = 8'h00;
	localparam logic [7:0] RST_HOUR = 8'h00;
	localparam logic [7:0] RST_DAY = 8'h01;
	localparam logic [2:0] RST_WDAY = 3'h6;
	localparam logic [7:0] RST_MON = 8'h01;
	localparam logic [7:0] RST_YEAR = 8'h00;
	localparam logic RST_OSC = 1'b1;

	// bcd limits of the counters
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [7:0] HUND_MAX = 8'h99;
	localparam logic [7:0] SEC_MAX = 8'h59;
	localparam logic [7:0] MIN_MAX = 8'h59;
	localparam logic [7:0] HR24_MAX = 8'h23;
	localparam logic [4:0] HR12_MAX = 5'h12;
	localparam logic [4:0] HR12_NOON = 5'h11;
	localparam logic [4:0] HR12_FIRST = 5'h01;
	localparam logic [7:0] DAY_FIRST = 8'h01;
	localparam logic [7:0] DAYS_31 = 8'h31;
	localparam logic [7:0] DAYS_30 = 8'h30;
	localparam logic [7:0] DAYS_29 = 8'h29;
	localparam logic [7:0] DAYS_28 = 8'h28;
	localparam logic [2:0] WDAY_MAX = 3'h6;
	localparam logic [7:0] MON_FIRST = 8'h01;
	localparam logic [7:0] MON_MAX = 8'h12;
	localparam logic [7:0] MON_FEB = 8'h02;
	localparam logic [7:0] MON_APR = 8'h04;
	localparam logic [7:0] MON_JUN = 8'h06;
	localparam logic [7:0] MON_SEP = 8'h09;
	localparam logic [7:0] MON_NOV = 8'h11;
	localparam logic [7:0] YEAR_MAX = 8'h99;

	// tick prescaler used while hundredths are disabled: 100 ticks per second
	localparam logic [6:0] PRESCALE_MAX = 7'h63;

	// register request from the serial front end, same clock domain
	typedef struct packed {
		logic wr;
		logic snap;
		logic [2:0] addr;
		logic [7:0] wdata;
	} rtcd_reg_req_t;

	// the eight live register bytes as presented to the reader
	typedef logic [NUM_REGS-1:0][7:0] rtcd_regs_t;

endpackage

/* File: rtcd_sync.sv */
// rtcd_sync: two-flop synchroniser with rising-edge detect
// assumes: d comes from outside the ref_clk domain
`timescale 1ns/100ps
module rtcd_sync (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// asynchronous level in
	input wire logic d,
	// synchronised level and its rising edge
	output logic q,
	output logic rise
);

	logic meta;
	logic last;

	// first flop feeds only the second
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta <= 1'b0;
			q <= 1'b0;
			last <= 1'b0;
		end else if (clk_en) begin
			meta <= d;
			q <= meta;
			last <= q;
		end
	end

	// edge of the settled level
	assign rise = q & ~last & clk_en;

endmodule

/* File: rtcd_snapshot.sv */
// rtcd_snapshot: output holding register, copies all eight bytes at once
// assumes: snap and addr come from logic on ref_clk
`timescale 1ns/100ps
module rtcd_snapshot (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// capture control
	input wire logic snap,
	input wire logic [2:0] addr,
	input wire rtcd_pkg::rtcd_regs_t live,
	// held byte
	output logic [7:0] rd_data
);

	logic [7:0] hold [rtcd_pkg::NUM_REGS];

	// copy every byte in one cycle so no carry splits the set
	for (genvar i = 0; i < rtcd_pkg::NUM_REGS; i++) begin : g_hold
		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				hold[i] <= 8'h00;
			end else if (clk_en && snap) begin
				hold[i] <= live[i];
			end
		end
	end

	// selected byte, read from the held copy
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data <= 8'h00;
		end else if (clk_en) begin
			rd_data <= hold[addr];
		end
	end

endmodule

/* File: rtcd_time_regs.sv */
// rtcd_time_regs: calendar-mode time and date counters with status bits
// assumes: tick_100hz and osc_running arrive from outside ref_clk;
// reg_req, flags and mode inputs come from logic on ref_clk
`timescale 1ns/100ps
module rtcd_time_regs (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// timing pins
	input wire logic tick_100hz,
	input wire logic osc_running,
	// mode settings
	input wire logic stopwatch_mode_select,
	input wire logic hundredths_enable,
	input wire logic hour_12_mode,
	// flags register contents
	input wire logic [7:0] flags,
	// register access
	input wire rtcd_pkg::rtcd_reg_req_t reg_req,
	output logic [7:0] rd_data,
	// status
	output logic oscillator_halt_flag,
	output logic flag_summary_bit
);

	logic tick;
	logic osc_ok;
	logic [7:0] hund;
	logic [6:0] prescale;
	logic [7:0] sec;
	logic [7:0] min;
	logic [7:0] hour;
	logic [7:0] day;
	logic [2:0] wday;
	logic [7:0] mon;
	logic [7:0] year;
	logic step;
	logic sec_step;
	logic min_step;
	logic hour_step;
	logic day_step;
	logic mon_step;
	logic year_step;
	logic [7:0] next_hour;
	logic [7:0] hour12_inc;
	logic hour_wrap;
	rtcd_pkg::rtcd_regs_t live;

	// add one to a bcd pair, units wrap into tens
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = v;
		if (v[3:0] == rtcd_pkg::DIGIT_MAX) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

	// year divisible by four, taken straight from the bcd digits
	function automatic logic leap_year(input logic [7:0] y);
		logic [1:0] m;
		m = y[1:0] + {y[4], 1'b0};
		return m == 2'h0;
	endfunction

	// last day of the month in bcd
	function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
		logic [7:0] r;
		r = rtcd_pkg::DAYS_31;
		if (m == rtcd_pkg::MON_FEB) begin
			r = leap_year(y) ? rtcd_pkg::DAYS_29 : rtcd_pkg::DAYS_28;
		end else if (m == rtcd_pkg::MON_APR || m == rtcd_pkg::MON_JUN ||
				m == rtcd_pkg::MON_SEP || m == rtcd_pkg::MON_NOV) begin
			r = rtcd_pkg::DAYS_30;
		end
		return r;
	endfunction

	// write strobe for one register index
	function automatic logic wr_hit(input rtcd_pkg::rtcd_reg_req_t q, input logic [2:0] a);
		return q.wr && (q.addr == a);
	endfunction

	// pin synchronisers
	rtcd_sync u_tick_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.d(tick_100hz),
		.q(),
		.rise(tick)
	);

	rtcd_sync u_osc_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.d(osc_running),
		.q(osc_ok),
		.rise()
	);

	// one hundredth step, calendar mode only, a host write takes precedence
	assign step = tick & ~stopwatch_mode_select & ~reg_req.wr;

	// carry chain from hundredths up to years
	assign sec_step = step & (hundredths_enable ? (hund == rtcd_pkg::HUND_MAX) :
		(prescale == rtcd_pkg::PRESCALE_MAX));
	assign min_step = sec_step & (sec[6:0] == rtcd_pkg::SEC_MAX[6:0]);
	assign hour_step = min_step & (min[6:0] == rtcd_pkg::MIN_MAX[6:0]);
	assign day_step = hour_step & hour_wrap;
	assign mon_step = day_step & (day == month_last(mon, year));
	assign year_step = mon_step & (mon == rtcd_pkg::MON_MAX);

	// next hour in either format and whether the day rolls
	always_comb begin
		next_hour = bcd_inc(hour);
		hour12_inc = bcd_inc({3'h0, hour[4:0]});
		hour_wrap = 1'b0;
		if (hour_12_mode) begin
			if (hour[4:0] == rtcd_pkg::HR12_MAX) begin
				next_hour = {2'h0, hour[rtcd_pkg::PM_BIT], rtcd_pkg::HR12_FIRST};
			end else if (hour[4:0] == rtcd_pkg::HR12_NOON) begin
				next_hour = {2'h0, ~hour[rtcd_pkg::PM_BIT], rtcd_pkg::HR12_MAX};
				hour_wrap = hour[rtcd_pkg::PM_BIT];
			end else begin
				// keep the pm bit, only the five count bits advance
				next_hour = {2'h0, hour[rtcd_pkg::PM_BIT], hour12_inc[4:0]};
			end
		end else if (hour == rtcd_pkg::HR24_MAX) begin
			next_hour = 8'h00;
			hour_wrap = 1'b1;
		end
	end

	// hundredths and the binary prescaler that replaces them when off
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hund <= rtcd_pkg::RST_HUND;
			prescale <= 7'h00;
		end else if (clk_en) begin
			if (!hundredths_enable) begin
				hund <= 8'h00;
				if (step) begin
					prescale <= (prescale == rtcd_pkg::PRESCALE_MAX) ? 7'h00 : prescale + 7'h01;
				end
			end else if (wr_hit(reg_req, rtcd_pkg::ADDR_HUND)) begin
				hund <= reg_req.wdata;
			end else if (step) begin
				hund <= (hund == rtcd_pkg::HUND_MAX) ? 8'h00 : bcd_inc(hund);
			end
		end
	end

	// seconds
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sec <= rtcd_pkg::RST_SEC;
		end else if (clk_en) begin
			if (wr_hit(reg_req, rtcd_pkg::ADDR_SEC)) begin
				sec <= {1'b0, reg_req.wdata[6:0]};
			end else if (sec_step) begin
				sec <= (sec[6:0] == rtcd_pkg::SEC_MAX[6:0]) ? 8'h00 : bcd_inc(sec);
			end
		end
	end

	// oscillator halt flag: stopped oscillator sets it, a write may clear it
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			oscillator_halt_flag <= rtcd_pkg::RST_OSC;
		end else if (clk_en) begin
			if (!osc_ok) begin
				oscillator_halt_flag <= 1'b1;
			end else if (wr_hit(reg_req, rtcd_pkg::ADDR_SEC)) begin
				oscillator_halt_flag <= reg_req.wdata[rtcd_pkg::OSC_BIT];
			end
		end
	end

	// minutes, the summary bit is never written
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			min <= rtcd_pkg::RST_MIN;
		end else if (clk_en) begin
			if (wr_hit(reg_req, rtcd_pkg::ADDR_MIN)) begin
				min <= {1'b0, reg_req.wdata[6:0]};
			end else if (min_step) begin
				min <= (min[6:0] == rtcd_pkg::MIN_MAX[6:0]) ? 8'h00 : bcd_inc(min);
			end
		end
	end

	// summary of the flags register, cleared only by clearing flags
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			flag_summary_bit <= 1'b0;
		end else if (clk_en) begin
			flag_summary_bit <= |flags;
		end
	end

	// hours
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			hour <= rtcd_pkg::RST_HOUR;
		end else if (clk_en) begin
			if (wr_hit(reg_req, rtcd_pkg::ADDR_HOUR)) begin
				hour <= reg_req.wdata & rtcd_pkg::MASK_HOUR;
			end else if (hour_step) begin
				hour <= next_hour;
			end
		end
	end

	// day of month, wraps at the month's last day
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			day <= rtcd_pkg::RST_DAY;
		end else if (clk_en) begin
			if (wr_hit(reg_req, rtcd_pkg::ADDR_DAY)) begin
				day <= reg_req.wdata & rtcd_pkg::MASK_DAY;
			end else if (day_step) begin
				day <= mon_step ? rtcd_pkg::DAY_FIRST : bcd_inc(day);
			end
		end
	end

	// weekday, three-bit cycle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wday <= rtcd_pkg::RST_WDAY;
		end else if (clk_en) begin
			if (wr_hit(reg_req, rtcd_pkg::ADDR_WDAY)) begin
				wday <= reg_req.wdata[2:0];
			end else if (day_step) begin
				wday <= (wday >= rtcd_pkg::WDAY_MAX) ? 3'h0 : wday + 3'h1;
			end
		end
	end

	// month
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mon <= rtcd_pkg::RST_MON;
		end else if (clk_en) begin
			if (wr_hit(reg_req, rtcd_pkg::ADDR_MON)) begin
				mon <= reg_req.wdata & rtcd_pkg::MASK_MON;
			end else if (mon_step) begin
				mon <= year_step ? rtcd_pkg::MON_FIRST : bcd_inc(mon);
			end
		end
	end

	// year, two bcd digits
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			year <= rtcd_pkg::RST_YEAR;
		end else if (clk_en) begin
			if (wr_hit(reg_req, rtcd_pkg::ADDR_YEAR)) begin
				year <= reg_req.wdata;
			end else if (year_step) begin
				year <= (year == rtcd_pkg::YEAR_MAX) ? 8'h00 : bcd_inc(year);
			end
		end
	end

	// bytes as the reader sees them
	always_comb begin
		live = '0;
		live[rtcd_pkg::ADDR_HUND] = hundredths_enable ? hund : 8'h00;
		live[rtcd_pkg::ADDR_SEC] = {oscillator_halt_flag, sec[6:0]};
		live[rtcd_pkg::ADDR_MIN] = {flag_summary_bit, min[6:0]};
		live[rtcd_pkg::ADDR_HOUR] = hour & rtcd_pkg::MASK_HOUR;
		live[rtcd_pkg::ADDR_DAY] = day & rtcd_pkg::MASK_DAY;
		live[rtcd_pkg::ADDR_WDAY] = {5'h00, wday};
		live[rtcd_pkg::ADDR_MON] = mon & rtcd_pkg::MASK_MON;
		live[rtcd_pkg::ADDR_YEAR] = year;
	end

	// holding register so the set is read from one instant
	rtcd_snapshot u_snapshot (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.snap(reg_req.snap),
		.addr(reg_req.addr),
		.live(live),
		.rd_data(rd_data)
	);

endmodule

/* File: rtcd_time_regs_unused_guard.sv */
`timescale 1ns/100ps

/* File: rtcd_time_regs_properties.sv */
// rtcd_time_regs_properties: port checks on the calendar register block
// assumes: bound to rtcd_time_regs, one ref_clk domain, clk_en held high
`timescale 1ns/100ps
module rtcd_time_regs_properties (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// inputs
	input wire logic osc_running,
	input wire logic hundredths_enable,
	input wire logic [7:0] flags,
	input wire rtcd_pkg::rtcd_reg_req_t reg_req,
	// outputs
	input wire logic [7:0] rd_data,
	input wire logic oscillator_halt_flag,
	input wire logic flag_summary_bit
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// status bits
	a_reset_status: assert property ($rose(rstn) |-> oscillator_halt_flag && !flag_summary_bit)
		else $error("status bits wrong after reset");
	a_summary_follows: assert property ($past(rstn) && $past(clk_en) |-> flag_summary_bit == |$past(flags))
		else $error("summary bit does not follow flags");
	a_halt_on_stop: assert property ((!osc_running)[*4] |-> ##[0:2] oscillator_halt_flag)
		else $error("halt flag not set while stopped");
	a_halt_sticky: assert property (oscillator_halt_flag && !(reg_req.wr && reg_req.addr == rtcd_pkg::ADDR_SEC) |=> oscillator_halt_flag)
		else $error("halt flag cleared without write");
	a_halt_clear_cause: assert property ($fell(oscillator_halt_flag) |-> $past(reg_req.wr) && $past(reg_req.addr) == rtcd_pkg::ADDR_SEC && !$past(reg_req.wdata[7]))
		else $error("halt flag fell without clearing write");
	// snapshot contents
	a_osc_in_read: assert property ((reg_req.snap && reg_req.addr == rtcd_pkg::ADDR_HUND) ##1 (!reg_req.snap)[*2] ##1 (reg_req.addr == rtcd_pkg::ADDR_SEC) |=> rd_data[7] == $past(oscillator_halt_flag, 4))
		else $error("seconds bit7 differs from halt flag");
	a_summary_in_read: assert property ((reg_req.snap && reg_req.addr == rtcd_pkg::ADDR_HUND) ##1 (!reg_req.snap)[*4] ##1 (reg_req.addr == rtcd_pkg::ADDR_MIN) |=> rd_data[7] == $past(flag_summary_bit, 6))
		else $error("minutes bit7 differs from summary");
	a_hund_off_zero: assert property ((!hundredths_enable)[*2] ##0 (reg_req.snap && reg_req.addr == rtcd_pkg::ADDR_HUND) ##1 (reg_req.addr == rtcd_pkg::ADDR_HUND) |=> rd_data == 8'h00)
		else $error("hundredths nonzero while disabled");
	a_hour_unused: assert property ($past(reg_req.addr) == rtcd_pkg::ADDR_HOUR |-> rd_data[7:6] == 2'h0)
		else $error("hours unused bits set");
	a_wday_unused: assert property ($past(reg_req.addr) == rtcd_pkg::ADDR_WDAY |-> rd_data[7:3] == 5'h00)
		else $error("weekday unused bits set");
	a_month_unused: assert property ($past(reg_req.addr) == rtcd_pkg::ADDR_MON |-> rd_data[7:5] == 3'h0)
		else $error("month unused bits set");
endmodule
bind rtcd_time_regs rtcd_time_regs_properties u_props (.ref_clk(ref_clk), .rstn(rstn),
	.clk_en(clk_en), .osc_running(osc_running), .hundredths_enable(hundredths_enable),
	.flags(flags), .reg_req(reg_req), .rd_data(rd_data),
	.oscillator_halt_flag(oscillator_halt_flag), .flag_summary_bit(flag_summary_bit));

/* File: rtcd_host_model.sv */
// rtcd_host_model: register-side host, whole-set writes and snapshot reads
// assumes: changes reg_req just after ref_clk rising edges
`timescale 1ns/100ps
module rtcd_host_model (
	// clock
	input wire logic ref_clk,
	// register port
	output rtcd_pkg::rtcd_reg_req_t reg_req,
	input wire logic [7:0] rd_data
);
	initial reg_req = '0;
	// eight bytes in consecutive cycles so no carry splits the set
	task automatic write_all(input rtcd_pkg::rtcd_regs_t d);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			reg_req <= '{1'b1, 1'b0, 3'(i), d[i]};
		end
		@(posedge ref_clk);
		reg_req.wr <= 1'b0;
	endtask
	// one capture, then walk the held bytes
	task automatic read_all(output rtcd_pkg::rtcd_regs_t v);
		@(posedge ref_clk);
		reg_req <= '{1'b0, 1'b1, 3'h0, 8'h00};
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			reg_req <= '{1'b0, 1'b0, 3'(i), 8'h00};
			@(posedge ref_clk);
			@(negedge ref_clk);
			v[i] = rd_data;
		end
		@(posedge ref_clk);
	endtask
endmodule

/* File: tb_top.sv */
// tb_top: self-checking bench for the calendar register block
// assumes: host model owns the register port, bench drives pins and modes
`timescale 1ns/100ps
module tb_top;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic tick_100hz = 1'b0;
	logic osc_running = 1'b0;
	logic stopwatch_mode_select = 1'b0;
	logic hundredths_enable = 1'b1;
	logic hour_12_mode = 1'b0;
	logic [7:0] flags = 8'h00;
	rtcd_pkg::rtcd_reg_req_t reg_req;
	logic [7:0] rd_data;
	logic oscillator_halt_flag;
	logic flag_summary_bit;
	rtcd_pkg::rtcd_regs_t got;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	// rollover cases: {year, month, weekday, day, hour, min, sec, hundredths}
	rtcd_pkg::rtcd_regs_t start_set [8] = '{64'h04_02_06_28_23_59_59_99,
		64'h03_02_02_28_23_59_59_99, 64'h99_12_03_31_23_59_59_99, 64'h10_05_01_05_11_59_59_99,
		64'h10_05_01_05_31_59_59_99, 64'h10_04_05_30_23_59_59_99, 64'h10_05_01_05_08_09_09_99,
		64'h10_05_01_05_29_59_59_99};
	rtcd_pkg::rtcd_regs_t exp_set [8] = '{64'h04_02_00_29_00_00_00_00,
		64'h03_03_03_01_00_00_00_00, 64'h00_01_04_01_00_00_00_00, 64'h10_05_01_05_32_00_00_00,
		64'h10_05_02_06_12_00_00_00, 64'h10_05_06_01_00_00_00_00, 64'h10_05_01_05_08_09_10_00,
		64'h10_05_01_05_30_00_00_00};
	logic h12 [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

	rtcd_time_regs dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(1'b1), .tick_100hz(tick_100hz),
		.osc_running(osc_running), .stopwatch_mode_select(stopwatch_mode_select),
		.hundredths_enable(hundredths_enable), .hour_12_mode(hour_12_mode), .flags(flags),
		.reg_req(reg_req), .rd_data(rd_data), .oscillator_halt_flag(oscillator_halt_flag),
		.flag_summary_bit(flag_summary_bit));
	rtcd_host_model host (.ref_clk(ref_clk), .reg_req(reg_req), .rd_data(rd_data));

	// clock and hang guard
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	task automatic chk(input logic [63:0] got_v, input logic [63:0] exp_v);
		check_count++;
		if (got_v !== exp_v) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask
	// status pins looked at mid-cycle, then back on a rising edge
	task automatic chk_status(input logic exp_osc, input logic exp_sum);
		@(negedge ref_clk);
		chk({62'h0, oscillator_halt_flag, flag_summary_bit}, {62'h0, exp_osc, exp_sum});
		@(posedge ref_clk);
	endtask
	// tick pin with a 32 ns period, still between bursts
	task automatic ticks(input int n);
		repeat (n) begin
			repeat (4) @(posedge ref_clk);
			tick_100hz <= 1'b1;
			repeat (4) @(posedge ref_clk);
			tick_100hz <= 1'b0;
		end
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic complete_run();
		if (num_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		chk_status(1'b1, 1'b0);
		host.read_all(got);
		chk(got, 64'h00_01_06_01_00_00_80_00);
		// clearing fails while stopped, works once running, sets again on stop
		host.write_all(64'h00_01_06_01_00_00_00_00);
		chk_status(1'b1, 1'b0);
		for (int k = 0; k < 2; k++) begin
			osc_running <= 1'b1;
			repeat (4) @(posedge ref_clk);
			host.write_all(64'h00_01_06_01_00_00_00_00);
			chk_status(1'b0, 1'b0);
			osc_running <= k[0];
			repeat (6) @(posedge ref_clk);
			chk_status(!k[0], 1'b0);
		end
		// summary bit set by flags, not by writes
		flags <= 8'h04;
		repeat (3) @(posedge ref_clk);
		chk_status(1'b0, 1'b1);
		host.write_all(64'h00_01_06_01_00_80_00_00);
		host.read_all(got);
		chk(64'(got[2]), 64'h80);
		flags <= 8'h00;
		repeat (3) @(posedge ref_clk);
		host.read_all(got);
		chk(64'(got[2]), 64'h00);
		// carries through every field, 12-hour pm included
		for (int c = 0; c < 8; c++) begin
			hour_12_mode <= h12[c];
			host.write_all(start_set[c]);
			ticks(1);
			host.read_all(got);
			chk(got, exp_set[c]);
		end
		// hundredths off: reads zero, write ignored, 100 ticks make one second
		hour_12_mode <= 1'b0;
		hundredths_enable <= 1'b0;
		host.write_all(64'h10_05_01_05_08_09_05_42);
		ticks(100);
		host.read_all(got);
		chk(got, 64'h10_05_01_05_08_09_06_00);
		// stopwatch select freezes calendar counting
		hundredths_enable <= 1'b1;
		stopwatch_mode_select <= 1'b1;
		ticks(20);
		host.read_all(got);
		chk(got, 64'h10_05_01_05_08_09_06_00);
		complete_run();
	end
endmodule
